// ===== src/timer_one_pkg.sv
/*
 timer one clock source package: register offsets, control field layout,
 reset values and timing constants.
 assumes a 32-bit classic wishbone register bus with byte addresses.
*/
package timer_one_pkg;

	// control register, low three bits steer the clock path
	typedef struct packed {
		logic [4:0] upper_bits;
		logic       ext_clock_sync_disable;
		logic       clock_source_select;
		logic       timer_run_enable;
	} timer_one_control_type;

	// one wishbone request as seen by the slave
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_type;

	localparam logic [3:0] CONTROL_OFFSET = 4'h0;
	localparam logic [3:0] COUNT_OFFSET   = 4'h4;
	localparam logic [3:0] STATUS_OFFSET  = 4'h8;

	localparam logic [7:0]  CONTROL_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET   = 16'h0000;

	// instruction clock is the reference divided by four
	localparam int          REF_CLK_MHZ          = 250;
	localparam int          INSTR_CLK_DIVIDE     = 4;
	localparam logic [1:0]  INSTR_DIV_LAST       = 2'(INSTR_CLK_DIVIDE - 1);
	localparam logic [1:0]  INSTR_DIV_RESET      = 2'h0;

	// status word layout
	localparam int STATUS_EXT_LEVEL_BIT = 0;
	localparam int STATUS_RUNNING_BIT   = 1;
	localparam int STATUS_OVERFLOW_BIT  = 2;

endpackage

// ===== src/timer_one_clock.sv
/*
 timer one clock source selection, external input synchronisation and
 run control, with a 16-bit count and a classic wishbone slave.
 assumes one reference clock; the external clock pin is asynchronous and
 is brought in through two flip-flops before any logic looks at it.
*/
// The implementer's own choices: the address map and register access over Wishbone.
`timescale 1ns/10ps

// Notes on behaviour
// R1: with the external source chosen and sync disable set, pin edges advance the count unaligned to the instruction clock.
// R2: with the external source chosen and sync disable clear, pin edges are aligned to the instruction clock first.
// R3: with the source select clear, the sync disable bit is ignored and the instruction clock drives the count.
// R4: source select one picks rising edges of the external pin, zero picks the instruction clock.
// R5: run enable one lets the timer count, zero stops it and holds the count.
// R6: in unaligned external mode each detected pin rising edge increments the count at once.
module timer_one_clock (
	input  wire logic        REF_CLK_I,
	input  wire logic        RST_I,
	input  wire logic        CYC_I,
	input  wire logic        STB_I,
	input  wire logic        WE_I,
	input  wire logic [3:0]  ADR_I,
	input  wire logic [3:0]  SEL_I,
	input  wire logic [31:0] DAT_I,
	output logic      [31:0] DAT_O,
	output logic             ACK_O,
	input  wire logic        EXT_CLOCK_INPUT_PIN_I,
	output logic      [15:0] COUNT_O,
	output logic             OVERFLOW_O
);

	timer_one_pkg::wb_req_type            req;
	timer_one_pkg::timer_one_control_type ctrl_q;
	logic [1:0]  div_q;
	logic        meta_q;
	logic        ext_sync_q;
	logic        ext_prev_q;
	logic        ext_pending_q;
	logic [15:0] count_q;
	logic        wrap_q;
	logic        ack_q;
	logic [31:0] rdata_q;

	wire         instr_tick;
	wire         ext_rise;
	wire         tick_sel;
	wire         advance;
	wire [15:0]  count_inc;
	wire         access;
	wire         wr_stb;
	wire         hit_ctrl;
	wire         hit_count;
	wire         hit_status;
	wire [31:0]  rdata_d;
	wire [15:0]  count_wr;
	wire [7:0]   ctrl_wr;

	assign req = '{cyc: CYC_I, stb: STB_I, we: WE_I, adr: ADR_I, sel: SEL_I, dat: DAT_I};

	// bus decode; answer one cycle after the request, unmapped reads zero
	assign access     = req.cyc && req.stb && !ack_q;
	assign wr_stb     = access && req.we;
	assign hit_ctrl   = req.adr == timer_one_pkg::CONTROL_OFFSET;
	assign hit_count  = req.adr == timer_one_pkg::COUNT_OFFSET;
	assign hit_status = req.adr == timer_one_pkg::STATUS_OFFSET;

	assign ctrl_wr  = req.sel[0] ? req.dat[7:0] : ctrl_q;
	assign count_wr = {req.sel[1] ? req.dat[15:8] : count_q[15:8],
	                   req.sel[0] ? req.dat[7:0] : count_q[7:0]};

	assign rdata_d = hit_ctrl   ? {24'h000000, ctrl_q} :
	                 hit_count  ? {16'h0000, count_q} :
	                 hit_status ? {29'h0, wrap_q, ctrl_q.timer_run_enable, ext_sync_q} :
	                 32'h00000000;

	// instruction clock enable from the reference divider
	assign instr_tick = div_q == timer_one_pkg::INSTR_DIV_LAST;

	// edge seen only after the two-stage synchroniser
	assign ext_rise = ext_sync_q && !ext_prev_q;

	// aligned mode waits for the next instruction tick; unaligned counts at once
	assign tick_sel = !ctrl_q.clock_source_select ? instr_tick :                 // R3 R4
	                  ctrl_q.ext_clock_sync_disable ? ext_rise :                  // R1 R6
	                  (instr_tick && (ext_pending_q || ext_rise));                // R2

	assign advance   = tick_sel && ctrl_q.timer_run_enable;                      // R5
	assign count_inc = count_q + 16'h0001;

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			div_q <= timer_one_pkg::INSTR_DIV_RESET;
		end else if (instr_tick) begin
			div_q <= timer_one_pkg::INSTR_DIV_RESET;
		end else begin
			div_q <= div_q + 2'h1;
		end
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			meta_q     <= 1'b0;
			ext_sync_q <= 1'b0;
			ext_prev_q <= 1'b0;
		end else begin
			meta_q     <= EXT_CLOCK_INPUT_PIN_I;
			ext_sync_q <= meta_q;
			ext_prev_q <= ext_sync_q;
		end
	end

	// remembers an edge until the instruction tick takes it
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ext_pending_q <= 1'b0;
		end else if (instr_tick) begin
			ext_pending_q <= 1'b0;
		end else if (ext_rise) begin
			ext_pending_q <= 1'b1; // R2
		end
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ctrl_q <= timer_one_pkg::CONTROL_RESET;
		end else if (wr_stb && hit_ctrl) begin
			ctrl_q <= ctrl_wr;
		end
	end

	// software write beats a same-cycle increment; count holds when stopped
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			count_q <= timer_one_pkg::COUNT_RESET;
		end else if (wr_stb && hit_count) begin
			count_q <= count_wr;
		end else if (advance) begin
			count_q <= count_inc; // R5
		end
	end

	// sticky wrap flag: a wrap in the clearing cycle wins over the clear
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			wrap_q     <= 1'b0;
			OVERFLOW_O <= 1'b0;
		end else begin
			OVERFLOW_O <= advance && (count_q == 16'hffff) && !(wr_stb && hit_count);
			if (advance && (count_q == 16'hffff)) begin
				wrap_q <= 1'b1;
			end else if (wr_stb && hit_status && req.sel[0] && req.dat[2]) begin
				wrap_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			ack_q   <= access;
			rdata_q <= access ? rdata_d : 32'h00000000;
		end
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			COUNT_O <= timer_one_pkg::COUNT_RESET;
		end else begin
			COUNT_O <= count_q;
		end
	end

	assign ACK_O = ack_q;
	assign DAT_O = rdata_q;

endmodule

// ===== tb/ext_clock_source.sv
/* far-side clock source for the timer pin.
 assumes the bench asks for bursts; the pin idles low between them. */
`timescale 1ns/10ps
module ext_clock_source (
	input  wire logic clk_i,
	input  wire logic en_i,
	input  wire logic slow_i,
	output logic      pin_o
);
	logic       pin_q = 1'b0;
	logic [2:0] wait_q = 3'h0;
	assign pin_o = pin_q;
	// a stop finishes the high phase, so no phase is under 3 cycles
	always_ff @(posedge clk_i)
		if (wait_q != 3'h0)
			wait_q <= wait_q - 3'h1;
		else if (en_i || pin_q) begin
			pin_q <= !pin_q;
			wait_q <= slow_i ? 3'h5 : 3'h2;
		end
endmodule

// ===== tb/timer_one_monitor.sv
/* assertions on the timer clock path.
 assumes binding to timer_one_clock; control is shadowed from bus writes. */
`timescale 1ns/10ps
module timer_one_monitor (
	input wire logic        REF_CLK_I,
	input wire logic        RST_I,
	input wire logic        STB_I,
	input wire logic        WE_I,
	input wire logic [3:0]  ADR_I,
	input wire logic [3:0]  SEL_I,
	input wire logic [31:0] DAT_I,
	input wire logic        ACK_O,
	input wire logic        EXT_CLOCK_INPUT_PIN_I,
	input wire logic [15:0] COUNT_O
);
	logic [2:0] ctl_q;
	wire        req = STB_I & !ACK_O;
	wire        ctl_wr = req & WE_I & SEL_I[0] & (ADR_I == timer_one_pkg::CONTROL_OFFSET);
	wire        intl = ctl_q[0] & !ctl_q[1] & !req;
	wire        ext = ctl_q[0] & ctl_q[1] & !req;
	wire        pin = EXT_CLOCK_INPUT_PIN_I;
	always_ff @(posedge REF_CLK_I or posedge RST_I)
		if (RST_I)
			ctl_q <= 3'h0;
		else if (ctl_wr)
			ctl_q <= DAT_I[2:0];
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);
	sequence s_tick; intl[*2] ##0 $changed(COUNT_O); endsequence
	sequence s_low; (ext && !pin)[*8]; endsequence
	property p_hold; (!ctl_q[0] && !req)[*3] |-> $stable(COUNT_O); endproperty
	property p_run; intl[*6] |-> COUNT_O != $past(COUNT_O, 5); endproperty
	property p_int; s_tick |-> COUNT_O == $past(COUNT_O) + 16'h1 ##1 $stable(COUNT_O)[*3];
	endproperty
	// unaligned: two flops, edge detect, count, output flop; fixed four cycles
	property p_unsync; ext && ctl_q[2] && $rose(pin) |-> ##4 $changed(COUNT_O); endproperty
	// aligned: same path plus up to three cycles waiting for the tick
	property p_sync; ext && !ctl_q[2] && $rose(pin) |-> ##[4:7] $changed(COUNT_O); endproperty
	property p_quiet; s_low |-> $stable(COUNT_O); endproperty
	a_hold: assert property (p_hold) else $error("count moved while stopped");
	a_run: assert property (p_run) else $error("count stuck while running");
	a_int: assert property (p_int) else $error("bad internal step");
	a_unsync: assert property (p_unsync) else $error("unaligned edge lost");
	a_sync: assert property (p_sync) else $error("aligned edge lost");
	a_quiet: assert property (p_quiet) else $error("count without pin edge");
endmodule
bind timer_one_clock timer_one_monitor i_mon (.REF_CLK_I, .RST_I, .STB_I, .WE_I, .ADR_I,
	.SEL_I, .DAT_I, .ACK_O, .EXT_CLOCK_INPUT_PIN_I, .COUNT_O);

// ===== tb/timer_one_clock_test.sv
/* self-checking bench for the timer clock path.
 assumes the slave acks one cycle after taking a request. */
`timescale 1ns/10ps
module timer_one_clock_test;
	logic                      clk = 1'b0;
	logic                      rst = 1'b1;
	logic                      en_q = 1'b0;
	logic                      slow_q = 1'b0;
	logic                      pin;
	logic                      pin_q = 1'b0;
	logic                      ack;
	logic [31:0]               rd;
	logic [31:0]               q;
	logic [15:0]               cnt;
	timer_one_pkg::wb_req_type req_q = '0;
	int                        bad_count = 0;
	int                        num_checks = 0;
	int                        rises = 0;
	int                        wraps = 0;
	logic                      ovf;
	always #2 clk = !clk;
	always @(posedge clk) begin
		pin_q <= pin;
		rises <= rises + int'(pin && !pin_q);
		wraps <= wraps + int'(ovf === 1'b1);
	end
	timer_one_clock i_dut (.REF_CLK_I(clk), .RST_I(rst), .CYC_I(req_q.cyc), .STB_I(req_q.stb),
		.WE_I(req_q.we), .ADR_I(req_q.adr), .SEL_I(req_q.sel), .DAT_I(req_q.dat), .DAT_O(rd),
		.ACK_O(ack), .EXT_CLOCK_INPUT_PIN_I(pin), .COUNT_O(cnt), .OVERFLOW_O(ovf));
	ext_clock_source i_src (.clk_i(clk), .en_i(en_q), .slow_i(slow_q), .pin_o(pin));
	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		req_q <= '{1'b1, 1'b1, w, a, 4'hf, d};
		@(posedge clk);
		while (ack !== 1'b1)
			@(posedge clk);
		q = rd;
		req_q.cyc <= 1'b0;
		req_q.stb <= 1'b0;
		@(posedge clk);
	endtask
	// pin runs in every mode, so ignored-pin cases are really exercised
	task automatic run_mode(input logic [2:0] ctl, input logic pace);
		logic [31:0] c0;
		int          r0;
		wb(1'b0, timer_one_pkg::COUNT_OFFSET, 32'h0);
		c0 = q;
		r0 = rises;
		wb(1'b1, timer_one_pkg::CONTROL_OFFSET, {29'h0, ctl});
		wb(1'b0, timer_one_pkg::CONTROL_OFFSET, 32'h0);
		chk(q, {29'h0, ctl});
		slow_q <= pace;
		en_q <= 1'b1;
		repeat (100) @(posedge clk);
		en_q <= 1'b0;
		repeat (30) @(posedge clk);
		wb(1'b1, timer_one_pkg::CONTROL_OFFSET, 32'h0);
		wb(1'b0, timer_one_pkg::COUNT_OFFSET, 32'h0);
		q = (q - c0) & 32'hffff;
		if (!ctl[0])
			chk(q, 32'h0);
		else if (!ctl[1])
			chk(32'(q inside {[32'd33:32'd35]}), 32'h1);
		else
			chk(q, 32'(rises - r0));
		$display("mode %h done", ctl);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		wb(1'b0, timer_one_pkg::CONTROL_OFFSET, 32'h0);
		chk(q, {24'h0, timer_one_pkg::CONTROL_RESET});
		wb(1'b1, 4'hc, 32'hff);
		wb(1'b0, 4'hc, 32'h0);
		chk(q, 32'h0);
		wb(1'b1, timer_one_pkg::COUNT_OFFSET, 32'hfff0);
		$display("reset test done");
		run_mode(3'h5, 1'b1);
		// count started at fff0 and ran 34 ticks, so it wrapped exactly once
		chk(32'(wraps), 32'h1);
		wb(1'b0, timer_one_pkg::STATUS_OFFSET, 32'h0);
		chk(q, 32'h4);
		wb(1'b1, timer_one_pkg::STATUS_OFFSET, 32'h4);
		wb(1'b0, timer_one_pkg::STATUS_OFFSET, 32'h0);
		chk(q, 32'h0);
		chk(32'(cnt), 32'h0012);
		run_mode(3'h7, 1'b0);
		run_mode(3'h3, 1'b0);
		run_mode(3'h6, 1'b0);
		close_out();
	end
	initial begin
		repeat (2000) @(posedge clk);
		bad_count++;
		close_out();
	end
endmodule
